// ---- verif/art_pin_model.sv ----
// partner: drives the external clock pin and the two capture pins of the timer
`timescale 1ns/1ns
module art_pin_model (
	input wire logic clk,
	output logic ext_clock_in,
	output logic [1:0] capture_input
);
	initial begin
		ext_clock_in = 1'b0;
		capture_input = 2'b10;
	end
	// hold sets the pace: short holds test the synchroniser, long ones a slow source
	task automatic ext_pulses(input int n, input int hold);
		repeat (n) begin
			@(posedge clk);
			ext_clock_in <= 1'b1;
			repeat (hold) @(posedge clk);
			ext_clock_in <= 1'b0;
			repeat (hold) @(posedge clk);
		end
	endtask : ext_pulses
	task automatic cap_set(input int ch, input logic lvl);
		@(posedge clk);
		capture_input[ch] <= lvl;
		repeat (4) @(posedge clk);
	endtask : cap_set
endmodule : art_pin_model

// ---- verif/art_timer_properties.sv ----
// checker: port-level assertions of the auto-reload pwm timer
`timescale 1ns/1ns
module art_timer_properties
	import art_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic [3:0] pwm_output_en,
	input wire logic overflow_irq,
	input wire logic [1:0] capture_irq,
	input wire logic wake_request
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	chk_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	chk_force_zero: assert property (
		$past(reg_read) && $past(reg_addr) == ADDR_TIMER_CSR |-> !reg_rdata[2])
		else $error("force reload bit read as one");
	chk_capt_reserved: assert property (
		$past(reg_read) && $past(reg_addr) == ADDR_CAPT_CSR |-> reg_rdata[7:6] == 2'b00)
		else $error("reserved capture bits not zero");
	chk_ovf_irq_gate: assert property (
		$past(reg_read) && $past(reg_addr) == ADDR_TIMER_CSR
		|-> overflow_irq == (reg_rdata[0] & reg_rdata[1]))
		else $error("overflow request not flag and enable");
	chk_capt_irq_level: assert property (
		$past(reg_read) && $past(reg_addr) == ADDR_CAPT_CSR
		|-> capture_irq == (reg_rdata[1:0] & reg_rdata[3:2]))
		else $error("capture request not flag and enable");
	chk_out_enable: assert property (
		$past(reg_read) && $past(reg_addr) == ADDR_PWM_CTRL |-> pwm_output_en == reg_rdata[7:4])
		else $error("pin enables differ from control bits");
	chk_wake_cause: assert property (wake_request |-> capture_irq != 2'b00)
		else $error("wake request without enabled capture");
	chk_counter_load: assert property (
		reg_write && reg_addr == ADDR_COUNTER && reg_wdata != 8'hFF
		##1 reg_read && reg_addr == ADDR_COUNTER
		|-> ##1 8'(reg_rdata - $past(reg_wdata, 2)) <= 8'h01)
		else $error("counter write not seen on read");
endmodule : art_timer_properties
bind art_timer art_timer_properties i_art_timer_properties (.clk, .rst_n, .reg_addr,
	.reg_wdata, .reg_write, .reg_read, .reg_rdata, .pwm_output_en, .overflow_irq,
	.capture_irq, .wake_request);

// ---- verif/art_timer_tb.sv ----
// testbench: registers, prescaler, overflow, pwm and capture of the auto-reload pwm timer
`timescale 1ns/1ns
module art_timer_tb;
	import art_pkg::*;
	logic clk, rst_n, reg_write, reg_read, ext_clock_in, overflow_irq, wake_request;
	logic [3:0] reg_addr, pwm_output, pwm_output_en, pol;
	logic [7:0] reg_wdata, reg_rdata, d, v;
	logic [1:0] capture_input, capture_irq;
	logic [7:0] duty [4];
	int miscompares, checks, seed, hi [4];
	art_timer i_art_timer (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.reg_rdata, .ext_clock_in, .capture_input, .pwm_output, .pwm_output_en,
		.overflow_irq, .capture_irq, .wake_request);
	art_pin_model i_art_pin_model (.clk, .ext_clock_in, .capture_input);
	// ----
	// tasks
	// ----
	task automatic test_done();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] w);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= w;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rc(input string what, input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
		chk(what, exp, d);
	endtask : rc
	task automatic wait_on(input bit cap);
		int k;
		k = 0;
		while ((cap ? capture_irq[0] : overflow_irq) !== 1'b1) begin
			@(posedge clk);
			#1;
			k++;
			if (k > 60) begin
				chk("interrupt wait", 8'h01, 8'h00);
				test_done();
			end
		end
	endtask : wait_on
	// reload is F0 here, so a period is sixteen counts
	function automatic int exp_high(input logic [7:0] dc, input logic p);
		return p ? 15 - (dc - 8'hF0) : dc - 8'hF0 + 1;
	endfunction : exp_high
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		seed = 32'h1ce4e6e8;
		rst_n = 1'b0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 16; a++) rc("reset", 4'(a), REG_RESET);
		for (int a = 4; a < 12; a++) begin
			v = $random(seed);
			if (a != 9) wr(4'(a), v);
			if (a != 9) rc("readback", 4'(a), v);
		end
		v = $random(seed);
		wr(ADDR_CAPT_CSR, v);
		rc("capture csr", ADDR_CAPT_CSR, v & 8'h3C);
		v = $random(seed) & 8'hF3;
		wr(ADDR_TIMER_CSR, v);
		rc("timer csr", ADDR_TIMER_CSR, v & 8'hF2);
		wr(ADDR_RELOAD, 8'h5A);
		wr(ADDR_TIMER_CSR, 8'h04);
		rc("force reload", ADDR_COUNTER, 8'h5A);
		$display("test registers done");
		for (int n = 0; n < 8; n++) begin
			wr(ADDR_TIMER_CSR, 8'(8'h08 | (n << 4)));
			wr(ADDR_COUNTER, 8'h00);
			repeat (8 << n) @(posedge clk);
			rc("divided count", ADDR_COUNTER, 8'((n == 0) ? 9 : 8));
			chk("count range", 8'h00, 8'(d > 8'h0A || d < 8'h07));
		end
		wr(ADDR_TIMER_CSR, 8'h00);
		rc("freeze", ADDR_COUNTER, d);
		repeat (20) @(posedge clk);
		rc("frozen counter", ADDR_COUNTER, d);
		wr(ADDR_TIMER_CSR, 8'h78);
		@(posedge clk);
		reg_addr <= ADDR_COUNTER;
		reg_wdata <= 8'h33;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 chk("on the fly", 8'h00, 8'(reg_rdata > 8'h34 || reg_rdata < 8'h33));
		wr(ADDR_TIMER_CSR, 8'h88);
		wr(ADDR_COUNTER, 8'h00);
		i_art_pin_model.ext_pulses(3, 2);
		i_art_pin_model.ext_pulses(2, 5);
		repeat (6) @(posedge clk);
		rc("external count", ADDR_COUNTER, 8'h05);
		$display("test prescaler done");
		wr(ADDR_RELOAD, 8'hF0);
		for (int it = 0; it < 3; it++) begin
			pol = $random(seed);
			for (int c = 0; c < 4; c++) begin
				duty[c] = (it == 0) ? 8'(8'hF0 + c * 5) : 8'hF0 | 8'($random(seed) & 15);
				wr(4'(7 - c), duty[c]);
			end
			wr(ADDR_PWM_CTRL, {4'hF, pol});
			wr(ADDR_TIMER_CSR, 8'h0E);
			wait_on(1'b0);
			rc("overflow set", ADDR_TIMER_CSR, 8'h0B);
			rc("overflow read clear", ADDR_TIMER_CSR, 8'h0A);
			repeat (40) @(posedge clk);
			hi = '{default: 0};
			repeat (16) begin
				@(posedge clk);
				#1;
				for (int c = 0; c < 4; c++) hi[c] += int'(pwm_output[c]);
			end
			for (int c = 0; c < 4; c++) chk("high count", 8'(exp_high(duty[c], pol[c])), 8'(hi[c]));
			chk("pin enables", 8'h0F, {4'h0, pwm_output_en});
		end
		for (int c = 4; c < 8; c++) wr(4'(c), 8'hFF);
		wr(ADDR_PWM_CTRL, 8'hF0);
		repeat (40) @(posedge clk);
		chk("steady level", 8'h0F, {4'h0, pwm_output});
		wr(ADDR_PWM_CTRL, 8'hFF);
		repeat (2) @(posedge clk);
		chk("polarity flip", 8'h00, {4'h0, pwm_output});
		$display("test pwm done");
		wr(ADDR_TIMER_CSR, 8'h00);
		wr(ADDR_COUNTER, 8'h47);
		wr(ADDR_HALT, 8'h01);
		wr(ADDR_CAPT_CSR, 8'h1C);
		i_art_pin_model.cap_set(0, 1'b1);
		wait_on(1'b1);
		@(posedge clk);
		chk("wake", 8'h01, {7'h0, wake_request});
		wr(ADDR_COUNTER, 8'h99);
		i_art_pin_model.cap_set(0, 1'b0);
		i_art_pin_model.cap_set(0, 1'b1);
		i_art_pin_model.cap_set(1, 1'b0);
		rc("capture flags", ADDR_CAPT_CSR, 8'h1F);
		rc("capture one", ADDR_CAPT1, 8'h47);
		rc("capture two", ADDR_CAPT2, 8'h99);
		rc("flags cleared", ADDR_CAPT_CSR, 8'h1C);
		$display("test capture done");
		test_done();
	end
endmodule : art_timer_tb

// ---- verilog/art_pkg.sv ----
// package: register map, field positions and reset values of the auto-reload pwm timer
package art_pkg;
	// ------------------------------------------------------------
	// register indices (8-bit registers, byte address = index)
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_DUTY3 = 4'h4;
	localparam logic [3:0] ADDR_DUTY2 = 4'h5;
	localparam logic [3:0] ADDR_DUTY1 = 4'h6;
	localparam logic [3:0] ADDR_DUTY0 = 4'h7;
	localparam logic [3:0] ADDR_PWM_CTRL = 4'h8;
	localparam logic [3:0] ADDR_TIMER_CSR = 4'h9;
	localparam logic [3:0] ADDR_COUNTER = 4'hA;
	localparam logic [3:0] ADDR_RELOAD = 4'hB;
	localparam logic [3:0] ADDR_CAPT_CSR = 4'hC;
	localparam logic [3:0] ADDR_CAPT1 = 4'hD;
	localparam logic [3:0] ADDR_CAPT2 = 4'hE;
	localparam logic [3:0] ADDR_HALT = 4'hF;
	// ------------------------------------------------------------
	// timer control/status fields
	// ------------------------------------------------------------
	localparam int EXT_CLOCK_SELECT_BIT = 7;
	localparam int COUNTER_CLOCK_DIV_HI = 6;
	localparam int COUNTER_CLOCK_DIV_LO = 4;
	localparam int COUNTER_RUN_BIT = 3;
	localparam int FORCE_RELOAD_BIT = 2;
	localparam int OVERFLOW_IRQ_EN_BIT = 1;
	localparam int OVERFLOW_FLAG_BIT = 0;
	// ------------------------------------------------------------
	// capture control/status fields
	// ------------------------------------------------------------
	localparam int CAPTURE_EDGE_LO = 4;
	localparam int CAPTURE_IRQ_EN_LO = 2;
	localparam int CAPTURE_FLAG_LO = 0;
	// ------------------------------------------------------------
	// other constants
	// ------------------------------------------------------------
	localparam int PWM_CHANNELS = 4;
	localparam int CAPTURE_CHANNELS = 2;
	localparam int PRESCALER_BITS = 7;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] COUNTER_TOP = 8'hFF;
endpackage : art_pkg

// ---- verilog/art_timer.sv ----
// module: 8-bit auto-reload pwm timer with prescaler, four pwm outputs and two captures
`timescale 1ns/1ns
module art_timer
	import art_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic ext_clock_in,
	input wire logic [1:0] capture_input,
	output logic [3:0] pwm_output,
	output logic [3:0] pwm_output_en,
	output logic overflow_irq,
	output logic [1:0] capture_irq,
	output logic wake_request
);
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0] timer_csr;
	logic [7:0] counter;
	logic [7:0] reload_value;
	logic [7:0] pwm_ctrl;
	logic [7:0] duty [PWM_CHANNELS];
	logic [7:0] compare_shadow [PWM_CHANNELS];
	logic [5:2] capt_cfg;
	logic [1:0] capture_flag;
	logic [7:0] capture_value [CAPTURE_CHANNELS];
	logic halt_mode;
	logic [PRESCALER_BITS-1:0] prescaler;
	logic [3:0] pwm_level;

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	wire wr_csr = reg_write && (reg_addr == ADDR_TIMER_CSR);
	wire wr_counter = reg_write && (reg_addr == ADDR_COUNTER);
	wire wr_reload = reg_write && (reg_addr == ADDR_RELOAD);
	wire wr_pwm_ctrl = reg_write && (reg_addr == ADDR_PWM_CTRL);
	wire wr_capt_csr = reg_write && (reg_addr == ADDR_CAPT_CSR);
	wire wr_halt = reg_write && (reg_addr == ADDR_HALT);
	wire rd_csr = reg_read && (reg_addr == ADDR_TIMER_CSR);
	wire [1:0] rd_capt;
	assign rd_capt[0] = reg_read && (reg_addr == ADDR_CAPT1);
	assign rd_capt[1] = reg_read && (reg_addr == ADDR_CAPT2);
	wire force_reload = wr_csr && reg_wdata[FORCE_RELOAD_BIT];

	// ------------------------------------------------------------
	// input synchronisers and edge detection
	// ------------------------------------------------------------
	logic [2:0] ext_sync;
	logic [2:0] cap_sync [CAPTURE_CHANNELS];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_sync <= 3'h0;
		end else begin
			ext_sync <= {ext_sync[1:0], ext_clock_in};
		end
	end
	wire ext_rise = ext_sync[1] && !ext_sync[2];

	// ------------------------------------------------------------
	// prescaler and counter
	// ------------------------------------------------------------
	wire ext_sel = timer_csr[EXT_CLOCK_SELECT_BIT];
	wire run = timer_csr[COUNTER_RUN_BIT];
	wire [2:0] div_sel = timer_csr[COUNTER_CLOCK_DIV_HI:COUNTER_CLOCK_DIV_LO];
	wire input_tick = run && (ext_sel ? ext_rise : 1'b1);
	// the tick is the falling edge of the selected prescaler tap
	wire [PRESCALER_BITS:0] next_prescaler_full = {1'b0, prescaler} + 8'h01;
	wire [PRESCALER_BITS-1:0] next_prescaler = next_prescaler_full[PRESCALER_BITS-1:0];
	wire [PRESCALER_BITS:0] tap_mask = (8'h01 << div_sel) - 8'h01;
	wire count_tick = input_tick &&
		((next_prescaler_full & tap_mask) == 8'h00);
	wire overflow = count_tick && (counter == COUNTER_TOP);

	// loading the counter either way also clears the prescaler, so counting
	// starts on a known phase
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prescaler <= '0;
		end else if (force_reload || wr_counter) begin
			prescaler <= '0;
		end else if (input_tick) begin
			prescaler <= next_prescaler;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			counter <= REG_RESET;
		end else if (wr_counter) begin
			counter <= reg_wdata;
		end else if (force_reload) begin
			counter <= reload_value;
		end else if (overflow) begin
			counter <= reload_value;
		end else if (count_tick) begin
			counter <= counter + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	wire [7:0] next_timer_csr;
	assign next_timer_csr[7:COUNTER_RUN_BIT] = wr_csr ? reg_wdata[7:COUNTER_RUN_BIT] :
		timer_csr[7:COUNTER_RUN_BIT];
	// the force-reload bit acts as a strobe and is never stored
	assign next_timer_csr[FORCE_RELOAD_BIT] = 1'b0;
	assign next_timer_csr[OVERFLOW_IRQ_EN_BIT] = wr_csr ? reg_wdata[OVERFLOW_IRQ_EN_BIT] :
		timer_csr[OVERFLOW_IRQ_EN_BIT];
	// set wins over the read that clears, so an overflow in the reading cycle is kept
	assign next_timer_csr[OVERFLOW_FLAG_BIT] = overflow ||
		(timer_csr[OVERFLOW_FLAG_BIT] && !rd_csr);
	wire [7:0] next_reload_value = wr_reload ? reg_wdata : reload_value;
	wire [7:0] next_pwm_ctrl = wr_pwm_ctrl ? reg_wdata : pwm_ctrl;
	wire [5:2] next_capt_cfg = wr_capt_csr ? reg_wdata[5:2] : capt_cfg;
	wire next_halt_mode = wr_halt ? reg_wdata[0] : halt_mode;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_csr <= REG_RESET;
		end else begin
			timer_csr <= next_timer_csr;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reload_value <= REG_RESET;
		end else begin
			reload_value <= next_reload_value;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_ctrl <= REG_RESET;
		end else begin
			pwm_ctrl <= next_pwm_ctrl;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			capt_cfg <= 4'h0;
		end else begin
			capt_cfg <= next_capt_cfg;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			halt_mode <= 1'b0;
		end else begin
			halt_mode <= next_halt_mode;
		end
	end

	// ------------------------------------------------------------
	// pwm channels
	// ------------------------------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < PWM_CHANNELS; ch++) begin : g_pwm
			localparam logic [3:0] DUTY_ADDR = ADDR_DUTY0 - 4'(ch);
			wire wr_duty = reg_write && (reg_addr == DUTY_ADDR);
			wire pol = pwm_ctrl[ch];
			wire next_pol = wr_pwm_ctrl ? reg_wdata[ch] : pol;
			wire pol_flip = wr_pwm_ctrl && (reg_wdata[ch] != pol);
			wire compare_hit = count_tick && !overflow &&
				(counter == compare_shadow[ch]);
			// a period restarts on overflow and on any load of the counter
			wire restart = overflow || force_reload || wr_counter;
			wire [7:0] next_duty = wr_duty ? reg_wdata : duty[ch];
			// the shadow moves only at overflow, so a duty write mid-period cannot glitch
			wire [7:0] next_compare = overflow ? duty[ch] : compare_shadow[ch];
			// level is the "counter <= compare" phase, polarity applied after
			wire next_level = restart ? 1'b1 : (compare_hit ? 1'b0 : pwm_level[ch]);
			wire next_out = overflow ? !next_pol :
				compare_hit ? next_pol :
				pol_flip ? !pwm_output[ch] :
				pwm_level[ch] ^ pol;
			wire next_en = wr_pwm_ctrl ? reg_wdata[ch+4] : pwm_ctrl[ch+4];

			// ------------------------------------------------------------
			// pwm state registers
			// ------------------------------------------------------------
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					duty[ch] <= REG_RESET;
				end else begin
					duty[ch] <= next_duty;
				end
			end

			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					compare_shadow[ch] <= REG_RESET;
				end else begin
					compare_shadow[ch] <= next_compare;
				end
			end

			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					pwm_level[ch] <= 1'b0;
				end else begin
					pwm_level[ch] <= next_level;
				end
			end

			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					pwm_output[ch] <= 1'b0;
				end else begin
					pwm_output[ch] <= next_out;
				end
			end

			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					pwm_output_en[ch] <= 1'b0;
				end else begin
					pwm_output_en[ch] <= next_en;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// capture channels
	// ------------------------------------------------------------
	generate
		for (ch = 0; ch < CAPTURE_CHANNELS; ch++) begin : g_capt
			// the first stage is read only by the second, never by logic
			wire rise = cap_sync[ch][1] && !cap_sync[ch][2];
			wire fall = !cap_sync[ch][1] && cap_sync[ch][2];
			wire edge_sel = capt_cfg[CAPTURE_EDGE_LO + ch];
			wire hit = edge_sel ? rise : fall;
			// a new edge in the reading cycle is kept; set wins
			wire take = hit && (!capture_flag[ch] || rd_capt[ch]);
			wire next_flag = take || (capture_flag[ch] && !rd_capt[ch]);
			wire [7:0] next_capture = take ? counter : capture_value[ch];

			// ------------------------------------------------------------
			// capture state registers
			// ------------------------------------------------------------
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					cap_sync[ch] <= 3'h0;
				end else begin
					cap_sync[ch] <= {cap_sync[ch][1:0], capture_input[ch]};
				end
			end

			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					capture_flag[ch] <= 1'b0;
				end else begin
					capture_flag[ch] <= next_flag;
				end
			end

			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					capture_value[ch] <= REG_RESET;
				end else begin
					capture_value[ch] <= next_capture;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// interrupt and wake outputs
	// ------------------------------------------------------------
	wire [1:0] capt_irq_en = capt_cfg[CAPTURE_IRQ_EN_LO+1:CAPTURE_IRQ_EN_LO];
	wire [1:0] capt_pending = capture_flag & capt_irq_en;
	wire next_overflow_irq = timer_csr[OVERFLOW_FLAG_BIT] &&
		timer_csr[OVERFLOW_IRQ_EN_BIT];
	// halt does not stop the timer; it only lets a pending capture wake the chip
	wire next_wake = halt_mode && |capt_pending;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			overflow_irq <= 1'b0;
		end else begin
			overflow_irq <= next_overflow_irq;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			capture_irq <= 2'h0;
		end else begin
			capture_irq <= capt_pending;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_request <= 1'b0;
		end else begin
			wake_request <= next_wake;
		end
	end

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	// read data is zero outside the read slot, so an or-tree of slaves needs no gating
	logic [7:0] next_rdata;
	always_comb begin
		next_rdata = 8'h00;
		unique case (reg_addr)
			ADDR_DUTY3: next_rdata = duty[3];
			ADDR_DUTY2: next_rdata = duty[2];
			ADDR_DUTY1: next_rdata = duty[1];
			ADDR_DUTY0: next_rdata = duty[0];
			ADDR_PWM_CTRL: next_rdata = pwm_ctrl;
			ADDR_TIMER_CSR: next_rdata = timer_csr & 8'hFB;
			ADDR_COUNTER: next_rdata = counter;
			ADDR_RELOAD: next_rdata = reload_value;
			ADDR_CAPT_CSR: next_rdata = {2'b00, capt_cfg, capture_flag};
			ADDR_CAPT1: next_rdata = capture_value[0];
			ADDR_CAPT2: next_rdata = capture_value[1];
			ADDR_HALT: next_rdata = {7'h00, halt_mode};
			default: next_rdata = 8'h00;
		endcase
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule : art_timer
